// >>> include/trec_pkg.sv
// constants and carriers for the t1 receive error counters
// assumes a single 100 mhz ref_clk and a byte-wide register map on apb
package trec_pkg;
   // ----------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------
   localparam logic [7:0] LINE_HI_IDX = 8'h23; // line count bits 15..8
   localparam logic [7:0] LINE_LO_IDX = 8'h24; // line count bits 7..0
   localparam logic [7:0] HIGH_IDX = 8'h25; // oos 11..8 | path 11..8
   localparam logic [7:0] PATH_LO_IDX = 8'h26; // path count bits 7..0
   localparam logic [7:0] OOS_LO_IDX = 8'h27; // oos count bits 7..0
   localparam logic [7:0] CTRL_IDX = 8'h28; // control bits
   localparam logic [5:0] CTRL_RESET = 6'h00; // control after reset
   // ----------------------------------------
   // counter widths and thresholds
   // ----------------------------------------
   localparam int LINE_WIDTH = 16; // line violation count
   localparam int PATH_WIDTH = 12; // path violation count
   localparam int OOS_WIDTH = 12; // out-of-sync count
   localparam logic [4:0] ZERO_RUN_PLAIN = 5'h10; // 16 zeros
   localparam logic [4:0] ZERO_RUN_B8ZS = 5'h08; // 8 zeros
   // ----------------------------------------
   // update interval timing
   // ----------------------------------------
   localparam int CLK_FREQ_KHZ = 100000; // ref_clk rate
   localparam int ONE_SEC_MS = 1000; // long interval
   localparam int SHORT_MS = 42; // short interval
   localparam int SEC_CYCLES = ONE_SEC_MS * CLK_FREQ_KHZ;
   localparam int SHORT_CYCLES = SHORT_MS * CLK_FREQ_KHZ;
   // ----------------------------------------
   // carriers
   // ----------------------------------------
   // software control bits, msb first: interval select is bit 5, framing mode bit 0
   typedef struct packed {
      logic update_interval_select; // 1: 42 ms, 0: one second
      logic oos_count_select; // 1: multiframes, 0: pattern errors
      logic fs_error_count_enable; // d4: count fs too
      logic excess_zero_count_enable; // count zero runs
      logic b8zs_receive_enable; // b8zs decoding on
      logic framing_mode_select; // 1: esf, 0: d4
   } trec_ctrl_type;
   // per-bit events from the receive synchronizer
   typedef struct packed {
      logic bit_valid; // one received bit this cycle
      logic bit_zero; // that bit was a zero
      logic bipolar_violation; // bpv seen on that bit
      logic b8zs_codeword; // bpv belongs to a valid b8zs word
      logic crc6_error; // esf crc6 word in error
      logic ft_error; // ft bit in error
      logic fs_error; // fs bit in error
      logic fps_error; // fps bit in error
      logic multiframe_strobe; // one multiframe boundary
   } trec_event_type;
endpackage

// >>> verilog/trec_sat_counter.sv
// saturating event counter with snapshot register
// assumes inc and snap_stb are synchronous one-cycle strobes
module trec_sat_counter
   import trec_pkg::*;
#(
   parameter int WIDTH = 12
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // events
   input wire logic inc,
   input wire logic snap_stb,
   // snapshot
   output logic [WIDTH-1:0] snap_reg
);
   // ----------------------------------------
   // accumulator
   // ----------------------------------------
   logic [WIDTH-1:0] count_reg; // running count
   logic [WIDTH-1:0] count_next;
   wire at_max = &count_reg; // saturated
   wire [WIDTH-1:0] first = inc ? WIDTH'(1) : '0; // count after restart

   // hold at max instead of wrapping
   assign count_next = snap_stb ? first :
                       (inc && !at_max) ? count_reg + WIDTH'(1) :
                       count_reg;

   // count and snapshot together, all bytes from one interval
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count_reg <= '0;
         snap_reg <= '0;
      end else begin
         count_reg <= count_next;
         if (snap_stb) begin
            snap_reg <= count_reg;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_saturate;
      @(posedge ref_clk) disable iff (rst)
      (at_max && !snap_stb) |=> &count_reg;
   endproperty
   a_saturate: assert property (p_saturate) else $error("counter wrapped");

   property p_snapshot;
      @(posedge ref_clk) disable iff (rst)
      snap_stb |=> snap_reg == $past(count_reg) && count_reg == WIDTH'($past(inc));
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("snapshot lost count");
endmodule

// >>> verilog/trec_zero_run.sv
// detects runs of consecutive received zeros
// assumes bit_valid marks each received bit once
module trec_zero_run
   import trec_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // received bits
   input wire logic bit_valid,
   input wire logic bit_zero,
   input wire logic b8zs_on,
   // one pulse per run reaching the threshold
   output logic run_hit
);
   // ----------------------------------------
   // run length
   // ----------------------------------------
   logic [4:0] run_reg; // zeros so far, stops at threshold
   logic [4:0] run_next;
   wire [4:0] limit = b8zs_on ? ZERO_RUN_B8ZS : ZERO_RUN_PLAIN;
   wire zero_bit = bit_valid && bit_zero;

   // hit once, when the run first reaches the limit
   assign run_hit = zero_bit && (run_reg == limit - 5'h01);
   assign run_next = !bit_valid ? run_reg :
                     !bit_zero ? 5'h00 :
                     (run_reg < limit) ? run_reg + 5'h01 : run_reg;

   // run counter, cleared by any one
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         run_reg <= 5'h00;
      end else begin
         run_reg <= run_next;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_run_plain;
      @(posedge ref_clk) disable iff (rst)
      (zero_bit && !b8zs_on && run_reg == 5'h0f) |-> run_hit;
   endproperty
   a_run_plain: assert property (p_run_plain) else $error("16 zero run missed");

   property p_run_b8zs;
      @(posedge ref_clk) disable iff (rst)
      (zero_bit && b8zs_on && run_reg == 5'h07) |-> run_hit;
   endproperty
   a_run_b8zs: assert property (p_run_b8zs) else $error("8 zero run missed");
endmodule

// >>> verilog/trec_counters.sv
// receive error counters for one t1 framer, registers on apb
// assumes framer status strobes are synchronous to ref_clk
//
// Function
// - no b8zs: count bpv and 16-zero runs
// - b8zs: count bpv and 8-zero runs
// - otherwise bpv only, skip b8zs words
// - esf: path counts crc6 errors
// - d4: path counts ft errors
// - d4 with fs enable: also fs
// - path count holds during sync loss
// - path bits split over 0x25 and 0x26
// - select one: count multiframes while unsynced
// - select zero: pattern errors, hold unsynced
// - oos bits split over 0x25 and 0x27
// - snapshot and restart each 1 s/42 ms
// - counters saturate, never roll over
// - line count 16 bits, always enabled
//
// Design decision made here: the APB slave port.
module trec_counters
   import trec_pkg::*;
#(
   parameter int SEC_COUNT = SEC_CYCLES, // one second in cycles
   parameter int SHORT_COUNT = SHORT_CYCLES // 42 ms in cycles
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // receive status
   input wire trec_event_type rx_event,
   input wire logic receive_sync_lost,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // update marker
   output logic update_pulse
);
   // ----------------------------------------
   // control register
   // ----------------------------------------
   trec_ctrl_type ctrl_reg; // software control
   wire esf = ctrl_reg.framing_mode_select;

   // ----------------------------------------
   // update interval timer
   // ----------------------------------------
   logic [31:0] tick_reg; // cycles into interval
   logic [31:0] tick_next;
   logic snap_stb; // end of interval
   wire [31:0] span = ctrl_reg.update_interval_select ?
                      32'(SHORT_COUNT) : 32'(SEC_COUNT);

   // interval ends on the last cycle of the span
   assign snap_stb = tick_reg >= span - 32'h0000_0001;
   assign tick_next = snap_stb ? 32'h0000_0000 : tick_reg + 32'h0000_0001;

   // timer and marker
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tick_reg <= 32'h0000_0000;
         update_pulse <= 1'b0;
      end else begin
         tick_reg <= tick_next;
         update_pulse <= snap_stb;
      end
   end

   // ----------------------------------------
   // line code violations
   // ----------------------------------------
   logic zero_hit; // zero run reached its limit
   logic bpv_counted; // bpv not part of a b8zs word
   logic line_inc;

   // zero run detector
   trec_zero_run u_zero_run (
      .ref_clk(ref_clk),
      .rst(rst),
      .bit_valid(rx_event.bit_valid),
      .bit_zero(rx_event.bit_zero),
      .b8zs_on(ctrl_reg.b8zs_receive_enable),
      .run_hit(zero_hit)
   );

   // intentional b8zs violations are not errors
   assign bpv_counted = rx_event.bipolar_violation &&
                        !(ctrl_reg.b8zs_receive_enable &&
                          rx_event.b8zs_codeword);
   // never gated by sync loss
   assign line_inc = bpv_counted ||
                     (ctrl_reg.excess_zero_count_enable && zero_hit);

   // ----------------------------------------
   // path code violations
   // ----------------------------------------
   logic d4_frame_err; // ft, plus fs when enabled
   logic path_inc;

   assign d4_frame_err = rx_event.ft_error ||
                         (ctrl_reg.fs_error_count_enable &&
                          rx_event.fs_error);
   // crc in esf, frame bits in d4, nothing while unsynced
   assign path_inc = !receive_sync_lost &&
                     (esf ? rx_event.crc6_error : d4_frame_err);

   // ----------------------------------------
   // multiframes out of sync or pattern errors
   // ----------------------------------------
   logic pattern_err; // ft in d4, fps in esf
   logic oos_inc;

   assign pattern_err = esf ? rx_event.fps_error : rx_event.ft_error;
   assign oos_inc = ctrl_reg.oos_count_select ?
                    (receive_sync_lost && rx_event.multiframe_strobe) :
                    (!receive_sync_lost && pattern_err);

   // ----------------------------------------
   // counters, all snapped on the same edge
   // ----------------------------------------
   logic [LINE_WIDTH-1:0] line_snap;
   logic [PATH_WIDTH-1:0] path_snap;
   logic [OOS_WIDTH-1:0] oos_snap;

   // line violation counter
   trec_sat_counter #(.WIDTH(LINE_WIDTH)) u_line (
      .ref_clk(ref_clk),
      .rst(rst),
      .inc(line_inc),
      .snap_stb(snap_stb),
      .snap_reg(line_snap)
   );

   // path violation counter
   trec_sat_counter #(.WIDTH(PATH_WIDTH)) u_path (
      .ref_clk(ref_clk),
      .rst(rst),
      .inc(path_inc),
      .snap_stb(snap_stb),
      .snap_reg(path_snap)
   );

   // out-of-sync counter
   trec_sat_counter #(.WIDTH(OOS_WIDTH)) u_oos (
      .ref_clk(ref_clk),
      .rst(rst),
      .inc(oos_inc),
      .snap_stb(snap_stb),
      .snap_reg(oos_snap)
   );

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire [7:0] idx = paddr[9:2]; // register index
   wire aligned = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00;
   wire mapped = aligned && idx >= LINE_HI_IDX && idx <= CTRL_IDX;
   wire access = psel && penable && !pready; // first access cycle
   wire ctrl_wr = access && pwrite && mapped && idx == CTRL_IDX;
   logic [7:0] rd_byte; // selected register byte

   // counter bytes are read-only; writes to them are dropped
   always_comb begin
      rd_byte = 8'h00;
      case (idx)
         LINE_HI_IDX: rd_byte = line_snap[15:8];
         LINE_LO_IDX: rd_byte = line_snap[7:0];
         HIGH_IDX: rd_byte = {oos_snap[11:8], path_snap[11:8]};
         PATH_LO_IDX: rd_byte = path_snap[7:0];
         OOS_LO_IDX: rd_byte = oos_snap[7:0];
         CTRL_IDX: rd_byte = {2'b00, ctrl_reg};
         default: rd_byte = 8'h00;
      endcase
   end

   // one wait state, then a one-cycle ready
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access && !mapped;
         prdata <= (access && !pwrite && mapped) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // control register write, taken at the ready edge
   logic ctrl_wr_reg; // write granted last cycle
   logic [5:0] wdata_reg; // its data
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_reg <= CTRL_RESET;
         ctrl_wr_reg <= 1'b0;
         wdata_reg <= 6'h00;
      end else begin
         ctrl_wr_reg <= ctrl_wr;
         wdata_reg <= pwdata[5:0];
         if (ctrl_wr_reg && psel && penable) begin
            ctrl_reg <= wdata_reg;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_bpv_codeword;
      @(posedge ref_clk) disable iff (rst)
      (ctrl_reg.b8zs_receive_enable && rx_event.b8zs_codeword && !zero_hit)
         |-> !line_inc;
   endproperty
   a_bpv_codeword: assert property (p_bpv_codeword) else $error("b8zs word counted");

   property p_line_unsynced;
      @(posedge ref_clk) disable iff (rst)
      (receive_sync_lost && rx_event.bipolar_violation && !rx_event.b8zs_codeword)
         |-> line_inc;
   endproperty
   a_line_unsynced: assert property (p_line_unsynced) else $error("line count gated");

   property p_path_crc;
      @(posedge ref_clk) disable iff (rst)
      (esf && !receive_sync_lost) |-> path_inc == rx_event.crc6_error;
   endproperty
   a_path_crc: assert property (p_path_crc) else $error("esf path count wrong");

   property p_path_ft;
      @(posedge ref_clk) disable iff (rst)
      (!esf && !receive_sync_lost && rx_event.ft_error) |-> path_inc;
   endproperty
   a_path_ft: assert property (p_path_ft) else $error("ft error missed");

   property p_path_fs;
      @(posedge ref_clk) disable iff (rst)
      (!esf && !receive_sync_lost && !rx_event.ft_error && rx_event.fs_error)
         |-> path_inc == ctrl_reg.fs_error_count_enable;
   endproperty
   a_path_fs: assert property (p_path_fs) else $error("fs count wrong");

   property p_path_hold;
      @(posedge ref_clk) disable iff (rst)
      receive_sync_lost |-> !path_inc;
   endproperty
   a_path_hold: assert property (p_path_hold) else $error("path counted unsynced");

   property p_oos_mf;
      @(posedge ref_clk) disable iff (rst)
      ctrl_reg.oos_count_select |->
         oos_inc == (receive_sync_lost && rx_event.multiframe_strobe);
   endproperty
   a_oos_mf: assert property (p_oos_mf) else $error("multiframe count wrong");

   property p_oos_pattern;
      @(posedge ref_clk) disable iff (rst)
      !ctrl_reg.oos_count_select |->
         oos_inc == (!receive_sync_lost && pattern_err);
   endproperty
   a_oos_pattern: assert property (p_oos_pattern) else $error("pattern count wrong");

   property p_high_byte;
      @(posedge ref_clk) disable iff (rst)
      (access && !pwrite && aligned && idx == HIGH_IDX) |=>
         prdata[7:0] == {$past(oos_snap[11:8]), $past(path_snap[11:8])};
   endproperty
   a_high_byte: assert property (p_high_byte) else $error("shared byte wrong");

   property p_interval;
      @(posedge ref_clk) disable iff (rst)
      snap_stb |=> !snap_stb && update_pulse;
   endproperty
   a_interval: assert property (p_interval) else $error("interval wrong");

   property p_read_only;
      @(posedge ref_clk) disable iff (rst)
      (access && pwrite && !snap_stb) |=> $stable(path_snap) && $stable(oos_snap);
   endproperty
   a_read_only: assert property (p_read_only) else $error("counter written");

   c_update: cover property (@(posedge ref_clk) disable iff (rst) update_pulse);
   c_read: cover property (@(posedge ref_clk) disable iff (rst) pready && !pslverr);
   c_zero: cover property (@(posedge ref_clk) disable iff (rst) zero_hit && line_inc);
   c_mf: cover property (@(posedge ref_clk) disable iff (rst) oos_inc && receive_sync_lost);
endmodule

// >>> verif/trec_rx_model.sv
// receive line partner: per-bit events and sync loss toward the counters
// assumes the bench calls emit and set_los from one process only
module trec_rx_model
   import trec_pkg::*;
(
   // clock
   input wire logic ref_clk,
   // receive status toward the counters
   output trec_event_type rx_event,
   output logic receive_sync_lost
);
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // idle line after time zero
   // ----------------------------------------
   initial begin
      rx_event = '0;
      receive_sync_lost = 1'b0;
   end

   // ----------------------------------------
   // stimulus tasks
   // ----------------------------------------
   // one event pulse, then an idle cycle without a valid bit
   task automatic emit(input logic [8:0] ev, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         rx_event <= trec_event_type'(ev);
         @(posedge ref_clk);
         rx_event <= '0;
      end
   endtask

   // synchronizer state changes on a clock edge
   task automatic set_los(input logic v);
      @(posedge ref_clk);
      receive_sync_lost <= v;
   endtask
endmodule

// >>> verif/trec_counters_tb_top.sv
// self-checking bench for the receive error counters
// assumes trec_rx_model drives the status side; apb master lives here
module trec_counters_tb_top
   import trec_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------
   // settings and event encodings (msb bit_valid .. lsb multiframe)
   // ----------------------------------------
   localparam int SPAN_LONG = 12000; // shortened one-second span
   localparam int SPAN_SHORT = 300; // shortened 42 ms span
   localparam int LIMIT = 60000; // hang guard in cycles
   localparam logic [8:0] E_ZERO = 9'h180; // valid zero bit
   localparam logic [8:0] E_ONE = 9'h100; // valid one bit
   localparam logic [8:0] E_BPV = 9'h140; // plain bipolar violation
   localparam logic [8:0] E_CW = 9'h160; // violation inside b8zs word
   localparam logic [8:0] E_CRC = 9'h010;
   localparam logic [8:0] E_FT = 9'h008;
   localparam logic [8:0] E_FS = 9'h004;
   localparam logic [8:0] E_FPS = 9'h002;
   localparam logic [8:0] E_MF = 9'h001;
   // control words: bit5 short interval, 4 oos select, 3 fs, 2 zeros, 1 b8zs, 0 esf

   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic update_pulse;
   trec_event_type rx_event;
   logic receive_sync_lost;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0; // cycle count
   int t_upd = 0; // cycle of last update seen
   int tnum = 0;
   int n1, n2, n3, n4; // random event counts
   logic [32:0] exp_q[$]; // expected {pslverr, prdata}

   always #5 ref_clk = ~ref_clk;

   trec_counters #(.SEC_COUNT(SPAN_LONG), .SHORT_COUNT(SPAN_SHORT)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .rx_event(rx_event),
      .receive_sync_lost(receive_sync_lost), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .update_pulse(update_pulse)
   );

   trec_rx_model i_model (
      .ref_clk(ref_clk), .rx_event(rx_event), .receive_sync_lost(receive_sync_lost)
   );

   // ----------------------------------------
   // checking and closing
   // ----------------------------------------
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // monitor: each answer takes the oldest note
   always @(posedge ref_clk) begin
      if (pready === 1'b1) begin
         check({pslverr, prdata}, (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1ffffffff);
      end
   end

   // cycle count and hang guard
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // ----------------------------------------
   // apb master and scenario helpers
   // ----------------------------------------
   // setup, access, hold until pready at an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      exp_q.push_back(e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk iff pready === 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [32:0] rd(input logic [7:0] v);
      return {25'h0, v};
   endfunction

   task automatic wait_upd();
      @(posedge ref_clk iff update_pulse === 1'b1);
   endtask

   task automatic rnd();
      n1 = 1 + $urandom % 20;
      n2 = 1 + $urandom % 20;
      n3 = 1 + $urandom % 20;
      n4 = 1 + $urandom % 20;
   endtask

   // program control, read it back, align to an interval start
   task automatic start(input logic [5:0] c);
      rnd();
      apb(1'b1, 12'h0a0, {26'h3ffffff, c}, 33'h0);
      apb(1'b0, 12'h0a0, 32'h0, rd({2'b00, c}));
      wait_upd();
      t_upd = cyc;
   endtask

   // next snapshot: span, read-only write, then all five bytes
   task automatic finish(input logic [15:0] l, input logic [11:0] p, input logic [11:0] o,
                         input int span);
      wait_upd();
      check(33'(cyc - t_upd), 33'(span));
      apb(1'b1, 12'h098, $urandom, 33'h0);
      apb(1'b0, 12'h08c, 32'h0, rd(l[15:8]));
      apb(1'b0, 12'h090, 32'h0, rd(l[7:0]));
      apb(1'b0, 12'h094, 32'h0, rd({o[11:8], p[11:8]}));
      apb(1'b0, 12'h098, 32'h0, rd(p[7:0]));
      apb(1'b0, 12'h09c, 32'h0, rd(o[7:0]));
      tnum++;
      $display("test %0d done", tnum);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'hc098c3b4));
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      // d4: bpv to line, ft to path and oos, fs ignored
      start(6'h20);
      i_model.emit(E_BPV, n1);
      i_model.emit(E_FT, n2);
      i_model.emit(E_FS, n3);
      finish(16'(n1), 12'(n2), 12'(n2), SPAN_SHORT);
      // d4 with fs: ft and fs to path, fps ignored
      start(6'h28);
      i_model.emit(E_FT, n1);
      i_model.emit(E_FS, n2);
      i_model.emit(E_FPS, n3);
      finish(16'h0, 12'(n1 + n2), 12'(n1), SPAN_SHORT);
      // esf: crc6 only in path, fps in oos
      start(6'h29);
      i_model.emit(E_CRC, n1);
      i_model.emit(E_FT, n2);
      i_model.emit(E_FS, n3);
      i_model.emit(E_FPS, n4);
      finish(16'h0, 12'(n1), 12'(n4), SPAN_SHORT);
      // zero runs without b8zs: 15 misses, 16 hits, 40 hits once
      start(6'h24);
      i_model.emit(E_ZERO, 15);
      i_model.emit(E_ONE, 1);
      i_model.emit(E_ZERO, 16);
      i_model.emit(E_ONE, 1);
      i_model.emit(E_ZERO, 40);
      i_model.emit(E_ONE, 1);
      i_model.emit(E_BPV, n1);
      finish(16'(2 + n1), 12'h0, 12'h0, SPAN_SHORT);
      // b8zs with zero count: 7 misses, 8 hits, code words skipped
      start(6'h26);
      i_model.emit(E_ZERO, 7);
      i_model.emit(E_ONE, 1);
      i_model.emit(E_ZERO, 8);
      i_model.emit(E_ONE, 1);
      i_model.emit(E_CW, n1);
      i_model.emit(E_BPV, n2);
      finish(16'(1 + n2), 12'h0, 12'h0, SPAN_SHORT);
      // b8zs without zero count
      start(6'h22);
      i_model.emit(E_ZERO, 20);
      i_model.emit(E_CW, n1);
      i_model.emit(E_BPV, n2);
      finish(16'(n2), 12'h0, 12'h0, SPAN_SHORT);
      // multiframe select: synced strobes ignored, unsynced counted
      start(6'h30);
      i_model.emit(E_MF, 2);
      i_model.set_los(1'b1);
      i_model.emit(E_MF | E_FT | E_CRC, n1);
      i_model.emit(E_BPV, n2);
      i_model.set_los(1'b0);
      finish(16'(n2), 12'h0, 12'(n1), SPAN_SHORT);
      // pattern select under sync loss: oos holds
      start(6'h20);
      i_model.set_los(1'b1);
      i_model.emit(E_FT | E_FPS | E_MF, n1);
      i_model.emit(E_BPV, n2);
      i_model.set_los(1'b0);
      finish(16'(n2), 12'h0, 12'h0, SPAN_SHORT);
      // long esf interval: fps saturates oos, 300 crc errors set distinct path nibbles
      start(6'h01);
      i_model.emit(E_BPV | E_FPS, 4200);
      i_model.emit(E_CRC, 300);
      finish(16'd4200, 12'h12c, 12'hfff, SPAN_LONG);
      // unmapped, misaligned and out-of-range accesses
      apb(1'b0, 12'h0a4, 32'h0, 33'h100000000);
      apb(1'b1, 12'h0a4, 32'h0, 33'h100000000);
      apb(1'b0, 12'h099, 32'h0, 33'h100000000);
      apb(1'b0, 12'h48c, 32'h0, 33'h100000000);
      apb(1'b0, 12'h088, 32'h0, 33'h100000000);
      $display("test %0d done", tnum + 1);
      repeat (2) @(posedge ref_clk);
      report_and_stop();
   end
endmodule
